// ===== inc/smq_pkg.sv
// Package for the SMBus transfer-mode sequencer: map, fields, timing and state
package smq_pkg;

   // ==========================================================
   // Register map (plain port, 8-bit data)
   localparam logic [2:0] ADR_CTRL = 3'h0;
   localparam logic [2:0] ADR_DATA = 3'h1;
   localparam logic [2:0] ADR_SADR = 3'h2;
   localparam logic [2:0] ADR_SMSK = 3'h3;
   localparam logic [2:0] ADR_CFG = 3'h4;

   // Control register bit positions; upper four form the status vector
   localparam int CB_SI = 0;
   localparam int CB_ACK = 1;
   localparam int CB_ARB = 2;
   localparam int CB_ACK_REQUEST_FLAG = 3;
   localparam int CB_STO = 4;
   localparam int CB_STA = 5;
   localparam int CB_TX = 6;
   localparam int CB_MST = 7;

   // Configuration register bit positions
   localparam int CFG_EN = 0;
   localparam int CFG_INH = 1;

   // ==========================================================
   // Field layout and reset values
   localparam int MSB = 7;
   localparam logic [3:0] ACK_SLOT = 4'h8;
   localparam logic [6:0] SLVM_RST = 7'h7F;
   localparam logic [6:0] GC_ADDR = 7'h00;

   // ==========================================================
   // Timing: half period of the generated serial clock
   localparam int CLK_NS = 10;
   localparam int SCL_HALF_NS = 5000;
   localparam int HALF_CYC_I = (SCL_HALF_NS + CLK_NS - 1) / CLK_NS;
   localparam logic [9:0] HALF_CYC = 10'(HALF_CYC_I);

   // ==========================================================
   // Types
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_START = 2'b01,
      ST_BYTE = 2'b10,
      ST_STOP = 2'b11
   } smq_st_e;

   typedef struct packed {
      logic [2:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } smq_req_s;

   typedef struct packed {
      smq_st_e st;
      logic master;
      logic transmit_direction_flag;
      logic start_request_bit;
      logic stop_request_bit;
      logic ack_request_flag;
      logic arbitration_lost_flag;
      logic ack;
      logic si;
      logic [7:0] dat;
      logic [6:0] slv;
      logic gc;
      logic [6:0] slvm;
      logic hw_acknowledge_enable;
      logic en;
      logic inhibit;
      logic [3:0] bitcnt;
      logic addr_ph;
      logic slave_act;
      logic ign;
      logic busy;
      logic frame_end;
      logic ack_go;
      logic wrote;
      logic [9:0] tmr;
      logic scl_m;
      logic scl_s;
      logic scl_d;
      logic sda_m;
      logic sda_s;
      logic sda_d;
      logic scl_oe;
      logic sda_oe;
      logic [7:0] rdata;
   } smq_state_s;

   // Sync stages reset to the pulled-up idle level, so no false edge follows reset
   localparam smq_state_s STATE_RST = '{st: ST_IDLE, slvm: SLVM_RST, scl_m: 1'b1, scl_s: 1'b1,
      scl_d: 1'b1, sda_m: 1'b1, sda_s: 1'b1, sda_d: 1'b1, default: '0};

endpackage

// ===== rtl/smq_sequencer.sv
// SMBus transfer-mode sequencer: master/slave, transmit/receive, byte interrupt
//
// Contract
// R1: Master from generated START until STOP/arbitration loss
// R2: Interrupt flag at end of every byte
// R3: Receive: interrupt before ack unless hardware ack
// R4: Transmit: interrupt always after the ack cycle
// R5: Master write: START, address with direction 0
// R6: Stop request ends master transfer with STOP
// R7: No data write after tx interrupt: receive
// R8: Master read: address bit 1, master drives clock
// R9: Software ack off: request flag, interrupt per byte
// R10: Hardware ack: drive preset ack, then interrupt
// R11: Ack bit 1 sends ACK, 0 NACK
// R12: Software NACKs final byte as master receiver
// R13: Data write as master receiver: become transmitter
// R14: Not inhibited: START plus address enters slave receive
// R15: Software ack off: interrupt, request flag on address
// R16: Hardware ack: ACK matching masked address
// R17: Ignored address: no slave interrupts until START
// R18: Received STOP leaves slave receiver mode
// R19: Data write as slave receiver: become transmitter
// R20: Slave tx: no data write after NACK
// R21: Slave tx leaves on STOP, reverts without write
// R22: Status vector is four upper control bits
// R23: Hardware ack enable selects recognition behaviour
// R24: Shift MSB first, first received bit at MSB
//
// The plain strobed port and the address map are this design's own decisions.
`timescale 1ns/1ps
module smq_sequencer
   import smq_pkg::*;
(
   input wire logic REF_CLK,
   input wire logic RST_N,
   input wire smq_req_s BUS_REQ,
   output logic [7:0] RDATA,
   input wire logic SCL_I,
   output logic SCL_O,
   output logic SCL_OE,
   input wire logic SDA_I,
   output logic SDA_O,
   output logic SDA_OE
);

   // ==========================================================
   // Helpers
   function automatic logic tdone(input logic [9:0] t);
      return t == (HALF_CYC - 10'h001);
   endfunction

   // Masked address compare, general call optional
   function automatic logic addr_hit(input logic [6:0] a, input logic [6:0] slv,
                                     input logic [6:0] msk, input logic gc);
      return (((a ^ slv) & msk) == 7'h00) || (gc && (a == GC_ADDR));
   endfunction

   smq_state_s s_r;
   smq_state_s s_nxt;
   logic rise;
   logic fall;
   logic start_det;
   logic stop_det;
   logic part;
   logic ackv;
   logic rel;
   logic [9:0] tnext;
   logic [7:0] wd;

   // ==========================================================
   // Bus line events, taken from the second and third sync stages
   assign rise = s_r.scl_s & ~s_r.scl_d;
   assign fall = ~s_r.scl_s & s_r.scl_d;
   assign start_det = s_r.scl_s & s_r.scl_d & s_r.sda_d & ~s_r.sda_s;
   assign stop_det = s_r.scl_s & s_r.scl_d & ~s_r.sda_d & s_r.sda_s;

   // Taking part in the current frame; an ignored slave sits out to next START
   assign part = s_r.master | s_r.slave_act |
                 (s_r.addr_ph & s_r.en & ~s_r.inhibit & ~s_r.ign); // R17
   // Address acknowledge comes from the compare only with hardware ack on
   assign ackv = (s_r.addr_ph & ~s_r.master & s_r.hw_acknowledge_enable) ?
                 addr_hit(s_r.dat[MSB:1], s_r.slv, s_r.slvm, s_r.gc) : s_r.ack; // R16 R11
   assign wd = BUS_REQ.wdata;
   // Software clearing a pending interrupt releases the bus
   assign rel = BUS_REQ.wr & (BUS_REQ.addr == ADR_CTRL) & ~wd[CB_SI] & s_r.si;
   assign tnext = s_r.tmr + 10'h001;

   // ==========================================================
   // Next state
   always_comb begin
      s_nxt = s_r;
      s_nxt.scl_m = SCL_I;
      s_nxt.scl_s = s_r.scl_m;
      s_nxt.scl_d = s_r.scl_s;
      s_nxt.sda_m = SDA_I;
      s_nxt.sda_s = s_r.sda_m;
      s_nxt.sda_d = s_r.sda_s;

      // Register reads, data valid in the following cycle
      s_nxt.rdata = 8'h00;
      if (BUS_REQ.rd) begin
         case (BUS_REQ.addr)
            ADR_CTRL: s_nxt.rdata = {s_r.master, s_r.transmit_direction_flag, s_r.start_request_bit, s_r.stop_request_bit,
                                     s_r.ack_request_flag, s_r.arbitration_lost_flag, s_r.ack, s_r.si}; // R22
            ADR_DATA: s_nxt.rdata = s_r.dat;
            ADR_SADR: s_nxt.rdata = {s_r.slv, s_r.gc};
            ADR_SMSK: s_nxt.rdata = {s_r.slvm, s_r.hw_acknowledge_enable};
            ADR_CFG: s_nxt.rdata = {6'h00, s_r.inhibit, s_r.en};
            default: s_nxt.rdata = 8'h00;
         endcase
      end

      // Register writes; hardware events below override, so a set wins
      if (BUS_REQ.wr) begin
         case (BUS_REQ.addr)
            ADR_CTRL: begin
               s_nxt.start_request_bit = wd[CB_STA];
               s_nxt.stop_request_bit = wd[CB_STO];
               s_nxt.ack = wd[CB_ACK]; // R11
               s_nxt.arbitration_lost_flag = s_r.arbitration_lost_flag & wd[CB_ARB];
               if (!wd[CB_SI]) begin
                  s_nxt.si = 1'b0;
               end
            end
            ADR_DATA: begin
               s_nxt.dat = wd;
               s_nxt.wrote = 1'b1; // R20
               if ((s_r.master | s_r.slave_act) & ~s_r.transmit_direction_flag) begin
                  s_nxt.transmit_direction_flag = 1'b1; // R13 R19
               end
            end
            ADR_SADR: {s_nxt.slv, s_nxt.gc} = wd;
            ADR_SMSK: {s_nxt.slvm, s_nxt.hw_acknowledge_enable} = wd; // R23
            ADR_CFG: begin
               s_nxt.en = wd[CFG_EN];
               s_nxt.inhibit = wd[CFG_INH];
            end
            default: ;
         endcase
      end

      // Interrupt release: a master's requests written along with the clear act at once unless an ack request is pending
      if (rel) begin
         s_nxt.wrote = 1'b0;
         s_nxt.ack_request_flag = 1'b0;
         s_nxt.ack_go = s_r.ack_request_flag; // R9
         if (!s_r.ack_request_flag && s_r.master && wd[CB_STO]) begin
            s_nxt.st = ST_STOP; // R6
            s_nxt.tmr = '0;
         end else if (!s_r.ack_request_flag && s_r.master && wd[CB_STA]) begin
            s_nxt.st = ST_START;
            s_nxt.tmr = '0;
         end else if (s_r.transmit_direction_flag && !s_r.wrote) begin
            s_nxt.transmit_direction_flag = 1'b0; // R7 R21
         end
      end

      case (s_r.st)
         // Wait for a start request on a free bus
         ST_IDLE: begin
            if (s_r.start_request_bit && s_r.en && !s_r.busy && !s_r.si) begin
               s_nxt.st = ST_START;
               s_nxt.tmr = '0;
            end
         end

         // Release a held clock, wait for a free bus, then pull SDA, then SCL
         ST_START: begin
            if (s_r.scl_oe) begin
               s_nxt.sda_oe = 1'b0;
               if (tdone(s_r.tmr)) begin
                  s_nxt.tmr = '0;
                  s_nxt.scl_oe = 1'b0;
               end else begin
                  s_nxt.tmr = tnext;
               end
            end else if (!s_r.sda_oe) begin
               if (s_r.scl_s && s_r.sda_s) begin
                  if (tdone(s_r.tmr)) begin
                     s_nxt.tmr = '0;
                     s_nxt.sda_oe = 1'b1;
                  end else begin
                     s_nxt.tmr = tnext;
                  end
               end else begin
                  s_nxt.tmr = '0;
               end
            end else if (tdone(s_r.tmr)) begin
               // START done: master, transmitter, software loads the address
               s_nxt.tmr = '0;
               s_nxt.scl_oe = 1'b1;
               s_nxt.master = 1'b1; // R1
               s_nxt.transmit_direction_flag = 1'b1; // R5 R8
               s_nxt.start_request_bit = 1'b0;
               s_nxt.si = 1'b1;
               s_nxt.bitcnt = '0;
               s_nxt.addr_ph = 1'b1;
               s_nxt.frame_end = 1'b0;
               s_nxt.st = ST_BYTE;
            end else begin
               s_nxt.tmr = tnext;
            end
         end

         // SDA low under low SCL, release SCL, then release SDA
         ST_STOP: begin
            if (tdone(s_r.tmr)) begin
               s_nxt.tmr = '0;
               if (!s_r.scl_oe && !s_r.sda_oe) begin
                  s_nxt.scl_oe = 1'b1;
               end else if (!s_r.sda_oe) begin
                  s_nxt.sda_oe = 1'b1;
               end else if (s_r.scl_oe) begin
                  s_nxt.scl_oe = 1'b0;
               end else if (s_r.scl_s) begin
                  s_nxt.sda_oe = 1'b0;
                  s_nxt.master = 1'b0; // R1 R6
                  s_nxt.transmit_direction_flag = 1'b0;
                  s_nxt.stop_request_bit = 1'b0;
                  s_nxt.st = s_r.start_request_bit ? ST_START : ST_IDLE;
               end
            end else if (!s_r.scl_oe && s_r.sda_oe && !s_r.scl_s) begin
               s_nxt.tmr = '0; // Clock held by another party
            end else begin
               s_nxt.tmr = tnext;
            end
         end

         ST_BYTE: begin
            // Master clock: halted while the interrupt is pending
            if (s_r.master) begin
               if (s_r.si) begin
                  s_nxt.tmr = '0;
               end else if (tdone(s_r.tmr)) begin
                  s_nxt.tmr = '0;
                  if (s_r.scl_oe) begin
                     s_nxt.scl_oe = 1'b0; // R8
                  end else if (s_r.scl_s) begin
                     s_nxt.scl_oe = 1'b1;
                  end
               end else begin
                  s_nxt.tmr = tnext;
               end
            end

            // SDA only changes while SCL is low, so no false START/STOP
            if (!part) begin
               s_nxt.sda_oe = 1'b0;
            end else if (!s_r.scl_s) begin
               if (s_r.bitcnt < ACK_SLOT) begin
                  s_nxt.sda_oe = s_r.transmit_direction_flag & ~s_r.dat[MSB]; // R24
               end else begin
                  s_nxt.sda_oe = ~s_r.transmit_direction_flag & (s_r.hw_acknowledge_enable | s_r.ack_go) & ackv; // R10 R11
               end
            end

            // Sample on rising SCL
            if (rise && part) begin
               if (s_r.bitcnt < ACK_SLOT) begin
                  s_nxt.dat = {s_r.dat[MSB-1:0], s_r.sda_s}; // R24
                  s_nxt.bitcnt = s_r.bitcnt + 4'h1;
                  if (s_r.master && s_r.transmit_direction_flag && s_r.dat[MSB] && !s_r.sda_s) begin
                     // Lost arbitration: drop master and both drivers
                     s_nxt.arbitration_lost_flag = 1'b1;
                     s_nxt.master = 1'b0; // R1
                     s_nxt.transmit_direction_flag = 1'b0;
                     s_nxt.scl_oe = 1'b0;
                     s_nxt.sda_oe = 1'b0;
                     s_nxt.tmr = '0;
                  end
               end else begin
                  s_nxt.bitcnt = '0;
                  s_nxt.ack_go = 1'b0;
                  s_nxt.frame_end = 1'b1;
                  if (s_r.transmit_direction_flag) begin
                     s_nxt.ack = ~s_r.sda_s;
                  end
                  if (s_r.addr_ph) begin
                     s_nxt.addr_ph = 1'b0;
                     if (!s_r.master && !s_r.sda_oe) begin
                        s_nxt.ign = 1'b1; // R17
                        s_nxt.slave_act = 1'b0;
                        s_nxt.frame_end = 1'b0;
                     end else if (!s_r.master) begin
                        s_nxt.slave_act = 1'b1; // R14
                     end
                  end
               end
            end

            // Interrupts posted on falling SCL, then the clock is held low
            if (fall && part) begin
               if (s_r.bitcnt == ACK_SLOT && !s_r.transmit_direction_flag && !s_r.hw_acknowledge_enable &&
                   !s_r.ack_go && !s_r.si) begin
                  s_nxt.si = 1'b1; // R3 R9
                  s_nxt.ack_request_flag = 1'b1; // R15
                  if (s_r.addr_ph && !s_r.master) begin
                     s_nxt.slave_act = 1'b1; // R14
                  end
               end
               if (s_r.frame_end) begin
                  s_nxt.frame_end = 1'b0;
                  if (s_r.transmit_direction_flag || s_r.hw_acknowledge_enable) begin
                     s_nxt.si = 1'b1; // R2 R4 R10
                  end else if (s_r.master && s_r.stop_request_bit) begin
                     s_nxt.st = ST_STOP; // R6
                     s_nxt.tmr = '0;
                  end else if (s_r.master && s_r.start_request_bit) begin
                     s_nxt.st = ST_START;
                     s_nxt.tmr = '0;
                  end
               end
            end

            // Slave stretches SCL low while its interrupt is pending
            if (!s_nxt.master) begin
               s_nxt.scl_oe = s_nxt.si & s_nxt.slave_act;
            end
         end

         default: s_nxt.st = ST_IDLE;
      endcase

      // START on the bus opens an address frame for a listening slave
      if (start_det) begin
         s_nxt.busy = 1'b1;
         if (!s_r.master && s_r.st != ST_START) begin
            s_nxt.st = ST_BYTE; // R14
            s_nxt.bitcnt = '0;
            s_nxt.addr_ph = 1'b1;
            s_nxt.ign = 1'b0; // R17
            s_nxt.slave_act = 1'b0;
            s_nxt.transmit_direction_flag = 1'b0;
            s_nxt.frame_end = 1'b0;
            s_nxt.scl_oe = 1'b0;
            s_nxt.sda_oe = 1'b0;
         end
      end

      // STOP on the bus ends any slave role
      if (stop_det) begin
         s_nxt.busy = 1'b0;
         if (!s_r.master && s_r.st != ST_START) begin
            s_nxt.st = ST_IDLE;
            s_nxt.slave_act = 1'b0; // R18 R21
            s_nxt.transmit_direction_flag = 1'b0;
            s_nxt.addr_ph = 1'b0;
            s_nxt.scl_oe = 1'b0;
            s_nxt.sda_oe = 1'b0;
         end
      end
   end

   // ==========================================================
   // State register
   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         s_r <= STATE_RST;
      end else begin
         s_r <= s_nxt;
      end
   end

   // Open-drain pins: only ever pull low
   assign RDATA = s_r.rdata;
   assign SCL_OE = s_r.scl_oe;
   assign SDA_OE = s_r.sda_oe;
   assign SCL_O = 1'b0;
   assign SDA_O = 1'b0;

endmodule

// ===== tb/smq_slave_model.sv
// Behavioural slave device on the far side of the two-wire bus
`timescale 1ns/1ps
module smq_slave_model #(
   parameter logic [6:0] ADDR = 7'h5A,
   parameter logic [7:0] TXB = 8'hA5
) (
   input wire logic scl,
   input wire logic sda,
   output logic sda_oe,
   output logic [7:0] last_byte,
   output logic ack_seen
);
   int cnt = 0;
   logic addr_ph = 1'b0;
   logic sel = 1'b0;
   logic rd = 1'b0;
   logic [7:0] sh = 8'h00;
   initial begin
      sda_oe = 1'b0;
      last_byte = 8'h00;
      ack_seen = 1'b0;
   end
   // ==========================================================
   // Bus conditions
   // START re-arms the address phase; the first clock fall is not a bit
   always @(negedge sda) begin
      if (scl === 1'b1) begin
         cnt = -1;
         addr_ph = 1'b1;
         sel = 1'b0;
         rd = 1'b0;
         sda_oe = 1'b0;
      end
   end
   // STOP deselects and releases the line to its pull-up
   always @(posedge sda) begin
      if (scl === 1'b1) begin
         sel = 1'b0;
         sda_oe = 1'b0;
      end
   end
   // ==========================================================
   // Bit engine
   // Sample on the rising clock, MSB first; ninth bit is the master's ack
   always @(posedge scl) begin
      if (cnt < 8) begin
         sh = {sh[6:0], sda};
      end else if (rd && sel) begin
         ack_seen = !sda;
      end
   end
   // Change data only while the clock is low
   always @(negedge scl) begin
      cnt = cnt + 1;
      if (cnt == 9) begin
         cnt = 0;
      end
      if (cnt == 8) begin
         if (addr_ph) begin
            sel = (sh[7:1] == ADDR);
            rd = sh[0];
            ack_seen = sel;
            addr_ph = 1'b0;
            sda_oe = sel;
         end else if (!rd) begin
            last_byte = sh;
            sda_oe = sel;
         end else begin
            sda_oe = 1'b0;
         end
      end else begin
         // A NACK from the master ends our sending
         sda_oe = sel && rd && ack_seen && !TXB[7 - cnt];
      end
   end
endmodule

// ===== tb/smq_sequencer_chk.sv
// Port-level assertion checker for the SMBus sequencer
`timescale 1ns/1ps
module smq_sequencer_chk
   import smq_pkg::*;
(
   input wire logic REF_CLK,
   input wire logic RST_N,
   input wire smq_req_s BUS_REQ,
   input wire logic [7:0] RDATA,
   input wire logic SCL_I,
   input wire logic SCL_O,
   input wire logic SCL_OE,
   input wire logic SDA_I,
   input wire logic SDA_O,
   input wire logic SDA_OE
);
   default clocking @(posedge REF_CLK); endclocking
   default disable iff (!RST_N);
   // ==========================================================
   // Phase counters
   // Lower bounds only: a stretched phase is legal, a short one is not
   logic [15:0] lo_cnt_r;
   logic [15:0] hi_cnt_r;
   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         lo_cnt_r <= 16'h0000;
         hi_cnt_r <= 16'h0000;
      end else begin
         lo_cnt_r <= SCL_OE ? lo_cnt_r + 16'h0001 : 16'h0000;
         hi_cnt_r <= SCL_OE ? 16'h0000 : hi_cnt_r + 16'(hi_cnt_r != 16'hFFFF);
      end
   end
   // ==========================================================
   // Bus conditions made by the design
   sequence s_start;
      $rose(SDA_OE) && SCL_I && !SCL_OE;
   endsequence
   sequence s_stop;
      $fell(SDA_OE) && SCL_I && !SCL_OE;
   endsequence
   property p_rdata_idle;
      !$past(BUS_REQ.rd) |-> RDATA == 8'h00;
   endproperty
   property p_pins_low;
      SCL_O == 1'b0 && SDA_O == 1'b0;
   endproperty
   property p_reset_idle;
      !$past(RST_N) |-> !SCL_OE && !SDA_OE;
   endproperty
   property p_start_hold;
      s_start |-> (SDA_OE && !SCL_OE) [*8];
   endproperty
   property p_start_scl;
      s_start |-> ##[1:1000] SCL_OE;
   endproperty
   property p_stop_free;
      s_stop |-> (!SCL_OE && !SDA_OE) [*8];
   endproperty
   property p_scl_lo;
      $fell(SCL_OE) |-> lo_cnt_r >= 16'h0190;
   endproperty
   property p_scl_hi;
      $rose(SCL_OE) |-> hi_cnt_r >= 16'h0190;
   endproperty
   a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read cycle");
   a_pins_low: assert property (p_pins_low) else $error("pin output level not zero");
   a_reset_idle: assert property (p_reset_idle) else $error("bus driven after reset");
   a_start_hold: assert property (p_start_hold) else $error("start not held");
   a_start_scl: assert property (p_start_scl) else $error("no clock after start");
   a_stop_free: assert property (p_stop_free) else $error("bus not free after stop");
   a_scl_lo: assert property (p_scl_lo) else $error("clock low phase short");
   a_scl_hi: assert property (p_scl_hi) else $error("clock high phase short");
endmodule
bind smq_sequencer smq_sequencer_chk i_smq_sequencer_chk (.REF_CLK(REF_CLK), .RST_N(RST_N),
   .BUS_REQ(BUS_REQ), .RDATA(RDATA), .SCL_I(SCL_I), .SCL_O(SCL_O), .SCL_OE(SCL_OE),
   .SDA_I(SDA_I), .SDA_O(SDA_O), .SDA_OE(SDA_OE));

// ===== tb/test_smq_sequencer.sv
// Testbench: master write and master read through the register port
`timescale 1ns/1ps
module test_smq_sequencer;
   import smq_pkg::*;
   logic REF_CLK = 1'b0;
   logic RST_N = 1'b0;
   smq_req_s req = '0;
   logic [7:0] rdata;
   logic scl_oe;
   logic sda_oe;
   logic m_sda_oe;
   logic scl_w;
   logic sda_w;
   logic [7:0] m_last;
   logic m_ack;
   logic [7:0] v;
   int err_total = 0;
   int total_checks = 0;
   always #5 REF_CLK = ~REF_CLK;
   // Open-drain wires with pull-ups
   assign scl_w = !scl_oe;
   assign sda_w = !(sda_oe || m_sda_oe);
   smq_sequencer i_smq_sequencer (.REF_CLK(REF_CLK), .RST_N(RST_N), .BUS_REQ(req),
      .RDATA(rdata), .SCL_I(scl_w), .SCL_O(), .SCL_OE(scl_oe), .SDA_I(sda_w), .SDA_O(),
      .SDA_OE(sda_oe));
   smq_slave_model i_smq_slave_model (.scl(scl_w), .sda(sda_w), .sda_oe(m_sda_oe),
      .last_byte(m_last), .ack_seen(m_ack));
   // ==========================================================
   // Report and compare
   task automatic give_verdict();
      $display("checks %0d errors %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // ==========================================================
   // Register port cycles
   task automatic bus_wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge REF_CLK);
      req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge REF_CLK);
      req <= '0;
   endtask
   // Read data stand only in the cycle after the strobe
   task automatic bus_rd(input logic [2:0] a, output logic [7:0] d);
      @(posedge REF_CLK);
      req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge REF_CLK);
      req <= '0;
      #1 d = rdata;
   endtask
   task automatic rd_chk(input logic [2:0] a, input logic [7:0] m, input logic [7:0] e);
      bus_rd(a, v);
      cmp8(v & m, e);
   endtask
   // Poll one control bit; a byte takes about 9000 cycles
   task automatic wait_ctrl(input int b, input logic lvl);
      int n;
      n = 0;
      bus_rd(ADR_CTRL, v);
      while (v[b] !== lvl) begin
         n++;
         if (n > 5000) begin
            err_total++;
            $display("[ERR] %0t wait timed out", $time);
            give_verdict();
         end
         bus_rd(ADR_CTRL, v);
      end
   endtask
   // Load a byte, clear the interrupt flag, wait for the next one
   task automatic send(input logic [7:0] d);
      bus_wr(ADR_DATA, d);
      bus_wr(ADR_CTRL, 8'h00);
      wait_ctrl(CB_SI, 1'b1);
   endtask
   // ==========================================================
   // Main sequence
   initial begin
      repeat (10) @(posedge REF_CLK);
      RST_N <= 1'b1;
      rd_chk(ADR_CTRL, 8'hFF, 8'h00);
      rd_chk(ADR_SMSK, 8'hFF, 8'hFE);
      rd_chk(3'h7, 8'hFF, 8'h00);
      // Slave side inhibited so only master behaviour is seen
      bus_wr(ADR_CFG, 8'h03);
      rd_chk(ADR_CFG, 8'h03, 8'h03);
      // Master write: address, one data byte, stop; the start request clears itself
      bus_wr(ADR_CTRL, 8'h20);
      wait_ctrl(CB_SI, 1'b1);
      rd_chk(ADR_CTRL, 8'hFD, 8'hC1);
      send(8'hB4);
      rd_chk(ADR_CTRL, 8'hFF, 8'hC3);
      send(8'h3C);
      rd_chk(ADR_CTRL, 8'hFF, 8'hC3);
      cmp8(m_last, 8'h3C);
      bus_wr(ADR_CTRL, 8'h10);
      wait_ctrl(CB_MST, 1'b0);
      rd_chk(ADR_CTRL, 8'hF1, 8'h00);
      // Master read: address with read bit, then one byte NACKed
      bus_wr(ADR_CTRL, 8'h20);
      wait_ctrl(CB_SI, 1'b1);
      rd_chk(ADR_CTRL, 8'hFD, 8'hC1);
      send(8'hB5);
      rd_chk(ADR_CTRL, 8'hFF, 8'hC3);
      bus_wr(ADR_CTRL, 8'h00);
      wait_ctrl(CB_SI, 1'b1);
      rd_chk(ADR_CTRL, 8'hF9, 8'h89);
      cmp8({7'h00, sda_oe}, 8'h00);
      rd_chk(ADR_DATA, 8'hFF, 8'hA5);
      // Last byte: NACK together with the stop request
      bus_wr(ADR_CTRL, 8'h10);
      wait_ctrl(CB_MST, 1'b0);
      cmp8({7'h00, m_ack}, 8'h00);
      rd_chk(ADR_CTRL, 8'hF1, 8'h00);
      // Hardware ack: ACK from the preset bit, NACK on the last byte, interrupt after it
      bus_wr(ADR_SMSK, 8'hFF);
      bus_wr(ADR_CTRL, 8'h20);
      wait_ctrl(CB_SI, 1'b1);
      send(8'hB5);
      bus_wr(ADR_CTRL, 8'h02);
      wait_ctrl(CB_SI, 1'b1);
      rd_chk(ADR_CTRL, 8'hFF, 8'h83);
      cmp8({7'h00, m_ack}, 8'h01);
      rd_chk(ADR_DATA, 8'hFF, 8'hA5);
      bus_wr(ADR_CTRL, 8'h00);
      wait_ctrl(CB_SI, 1'b1);
      rd_chk(ADR_CTRL, 8'hFF, 8'h81);
      cmp8({7'h00, m_ack}, 8'h00);
      bus_wr(ADR_CTRL, 8'h10);
      wait_ctrl(CB_MST, 1'b0);
      rd_chk(ADR_CTRL, 8'hF1, 8'h00);
      give_verdict();
   end
endmodule
